// File: include/sdpr_pkg.sv
package sdpr_pkg;

  localparam int unsigned ADDR_W   = 18;
  localparam int unsigned DATA_W   = 18;
  localparam int unsigned LANES    = 2;
  localparam int unsigned LANE_W   = 9;
  localparam int unsigned DEPTH    = 1 << ADDR_W;

  // Lane index and bit position of each byte lane
  localparam int unsigned LANE_LO  = 0;
  localparam int unsigned LANE_HI  = 1;
  localparam int unsigned LO_LSB   = 0;
  localparam int unsigned HI_LSB   = 9;

  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0_0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 18'h0_0001;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;
  localparam logic [LANES-1:0]  LANE_OFF = 2'h0;

  typedef enum logic [1:0] {
    SDPR_ADDR_HOLD,
    SDPR_ADDR_LOAD,
    SDPR_ADDR_STEP,
    SDPR_ADDR_REPEAT
  } sdpr_addr_op_t;

endpackage : sdpr_pkg

// File: hdl/sdpr_port.sv
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - With the active-low chip select high or the active-high chip select low, the port is deselected, lanes float and nothing is read or written.
// - A selected write stores input data into each lane whose active-low lane enable is low, upper lane bits 9-17 and lower lane bits 0-8, ignoring output enable.
// - A selected read with output enable low drives only the lanes whose lane enable is low, and with both lane enables high no lane is accessed.
// - Output enable acts without the clock and floats the data outputs while high, even during a selected read.
// - In flow-through mode read data appears in the access cycle, and in pipelined mode one clock later.
// - With pipeline select high the chip and lane enables are registered twice, so a deselect takes effect two cycles after it is sampled.
// - Address strobe low with repeat high loads the external address and uses it for the current access.
// - Address strobe, count enable and repeat all high reuse the previous internal address unchanged.
// - Address strobe high, repeat high and count enable low increment the internal address by one and use it for the access.
// - The counter advances whenever count enable is low with strobe and repeat high, whether or not the port is selected.
// - Address strobe and repeat act whether or not the port is selected.
// - Repeat low sets the internal address to the last strobed address, ahead of strobe and count enable.
// - Every address strobed with repeat high becomes the repeat target, and the master strobes a known address before relying on repeat.
// - Each later address strobe with repeat high overwrites the repeat target.
module sdpr_port (
  input  wire logic                         i_core_clk,
  input  wire logic                         i_srst,
  input  wire logic                         i_pipeline_select,
  input  wire logic                         i_chip_select_n,
  input  wire logic                         i_chip_select_hi,
  input  wire logic                         i_read_write,
  input  wire logic                         i_output_enable_n,
  input  wire logic                         i_upper_lane_enable_n,
  input  wire logic                         i_lower_lane_enable_n,
  input  wire logic                         i_addr_strobe_n,
  input  wire logic                         i_count_enable_n,
  input  wire logic                         i_repeat_n,
  input  wire logic [sdpr_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [sdpr_pkg::DATA_W-1:0]  i_data,
  output logic      [sdpr_pkg::DATA_W-1:0]  o_data,
  output logic      [sdpr_pkg::LANES-1:0]   o_data_oe_n,
  output logic      [sdpr_pkg::ADDR_W-1:0]  o_internal_addr
);

  logic [sdpr_pkg::DATA_W-1:0] mem [sdpr_pkg::DEPTH];
  logic [sdpr_pkg::ADDR_W-1:0] addr;
  logic [sdpr_pkg::ADDR_W-1:0] repeat_target;
  logic [sdpr_pkg::ADDR_W-1:0] next_addr;
  sdpr_pkg::sdpr_addr_op_t     addr_op;
  logic                        selected;
  logic [sdpr_pkg::LANES-1:0]  lane_en;
  logic [sdpr_pkg::LANES-1:0]  next_rd_lanes;
  logic [sdpr_pkg::LANES-1:0]  rd_lanes_s1;
  logic [sdpr_pkg::LANES-1:0]  rd_lanes_out;
  logic [sdpr_pkg::DATA_W-1:0] rd_data_s1;
  logic [sdpr_pkg::DATA_W-1:0] rd_word;

  // Expands a per-lane flag into a per-bit mask
  function automatic logic [sdpr_pkg::DATA_W-1:0] lane_mask(
    input logic [sdpr_pkg::LANES-1:0] lanes
  );
    lane_mask = {{sdpr_pkg::LANE_W{lanes[sdpr_pkg::LANE_HI]}},
                 {sdpr_pkg::LANE_W{lanes[sdpr_pkg::LANE_LO]}}};
  endfunction : lane_mask

  // Address operation; repeat outranks strobe, strobe outranks counting
  always_comb begin
    if (!i_repeat_n) begin
      addr_op = sdpr_pkg::SDPR_ADDR_REPEAT;
    end else if (!i_addr_strobe_n) begin
      addr_op = sdpr_pkg::SDPR_ADDR_LOAD;
    end else if (!i_count_enable_n) begin
      addr_op = sdpr_pkg::SDPR_ADDR_STEP;
    end else begin
      addr_op = sdpr_pkg::SDPR_ADDR_HOLD;
    end
  end

  always_comb begin
    case (addr_op)
      sdpr_pkg::SDPR_ADDR_REPEAT: next_addr = repeat_target;
      sdpr_pkg::SDPR_ADDR_LOAD:   next_addr = i_addr;
      // Natural wrap at the top of the address space
      sdpr_pkg::SDPR_ADDR_STEP:   next_addr = addr + sdpr_pkg::ADDR_ONE;
      sdpr_pkg::SDPR_ADDR_HOLD:   next_addr = addr;
      default:                    next_addr = addr;
    endcase
  end

  // Counter ignores chip and lane enables
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      addr <= sdpr_pkg::ADDR_RST;
    end else begin
      addr <= next_addr;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      repeat_target <= sdpr_pkg::ADDR_RST;
    end else if (addr_op == sdpr_pkg::SDPR_ADDR_LOAD) begin
      repeat_target <= i_addr;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_internal_addr <= sdpr_pkg::ADDR_RST;
    end else begin
      o_internal_addr <= next_addr;
    end
  end

  assign selected = !i_chip_select_n && i_chip_select_hi;
  assign lane_en  = {!i_upper_lane_enable_n, !i_lower_lane_enable_n};
  assign next_rd_lanes = (selected && i_read_write) ? lane_en : sdpr_pkg::LANE_OFF;

  // Write: per-lane merge, output enable plays no part
  always_ff @(posedge i_core_clk) begin
    if (selected && !i_read_write) begin
      mem[next_addr] <= (i_data & lane_mask(lane_en)) |
                        (mem[next_addr] & ~lane_mask(lane_en));
    end
  end

  assign rd_word = mem[next_addr];

  // First stage: data and lane drive of the access cycle
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rd_lanes_s1 <= sdpr_pkg::LANE_OFF;
      rd_data_s1  <= sdpr_pkg::DATA_RST;
    end else begin
      rd_lanes_s1 <= next_rd_lanes;
      rd_data_s1  <= rd_word;
    end
  end

  // Pipelined mode takes the second stage, so enables are held twice
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rd_lanes_out <= sdpr_pkg::LANE_OFF;
      o_data       <= sdpr_pkg::DATA_RST;
    end else if (i_pipeline_select) begin
      rd_lanes_out <= rd_lanes_s1;
      o_data       <= rd_data_s1;
    end else begin
      rd_lanes_out <= next_rd_lanes;
      o_data       <= rd_word;
    end
  end

  // Output enable gates the drivers without the clock
  assign o_data_oe_n = ~rd_lanes_out | {sdpr_pkg::LANES{i_output_enable_n}};

endmodule : sdpr_port

`default_nettype wire

// File: verif/sdpr_port_checker.sv
`timescale 1ns/10ps
`default_nettype none
module sdpr_port_checker (
  input wire logic        i_core_clk,
  input wire logic        i_srst,
  input wire logic        i_pipeline_select,
  input wire logic        i_chip_select_n,
  input wire logic        i_chip_select_hi,
  input wire logic        i_read_write,
  input wire logic        i_output_enable_n,
  input wire logic        i_upper_lane_enable_n,
  input wire logic        i_lower_lane_enable_n,
  input wire logic        i_addr_strobe_n,
  input wire logic        i_count_enable_n,
  input wire logic        i_repeat_n,
  input wire logic [17:0] i_addr,
  input wire logic [1:0]  o_data_oe_n,
  input wire logic [17:0] o_internal_addr
);
  wire logic       s  = !i_chip_select_n && i_chip_select_hi;
  wire logic       ft = !i_pipeline_select;
  wire logic [1:0] ln = {i_upper_lane_enable_n, i_lower_lane_enable_n};
  logic      [17:0] tgt;
  always_ff @(posedge i_core_clk)
    if (i_srst) tgt <= 18'h0_0000;
    else if (i_repeat_n && !i_addr_strobe_n) tgt <= i_addr;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  a_addr_load: assert property (!i_addr_strobe_n && i_repeat_n
    |=> o_internal_addr == $past(i_addr)) else $error("strobed address not taken");
  a_addr_hold: assert property (i_addr_strobe_n && i_count_enable_n && i_repeat_n
    |=> $stable(o_internal_addr)) else $error("held address moved");
  a_addr_step: assert property (i_addr_strobe_n && !i_count_enable_n && i_repeat_n
    |=> o_internal_addr == $past(o_internal_addr) + 18'h0_0001) else $error("no step");
  a_rpt_restore: assert property (!i_repeat_n
    |=> o_internal_addr == $past(tgt)) else $error("repeat target lost");
  a_desel_float: assert property (ft && !s
    |=> &o_data_oe_n) else $error("lane driven while deselected");
  a_oe_async: assert property (i_output_enable_n |-> &o_data_oe_n)
    else $error("lane driven with output enable high");
  a_lane_drive: assert property (ft && s && i_read_write ##1 !i_output_enable_n
    |-> o_data_oe_n == $past(ln)) else $error("wrong lanes driven");
  a_pipe_dcd: assert property (i_pipeline_select && !s |-> ##2 &o_data_oe_n)
    else $error("deselect not after two cycles");
  c_rpt: cover property (!i_repeat_n && s);
  c_ft_read: cover property (ft && s && i_read_write && !i_output_enable_n);
  c_pipe_read: cover property (i_pipeline_select && s && i_read_write);
endmodule : sdpr_port_checker
`default_nettype wire

// File: verif/sdpr_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdpr_master_model (
  input  wire logic        i_clk,
  output logic      [8:0]  o_ctl = 9'h17F,
  output logic      [17:0] o_addr = 18'h0_0000,
  output logic      [17:0] o_data = 18'h0_0000
);
  // Control order: cs_n, cs_hi, rw, oe_n, ub_n, lb_n, ads_n, cnt_n, rpt_n
  task automatic op(input logic [8:0] c, input logic [17:0] a, d);
    @(negedge i_clk);
    o_ctl <= c;
    o_addr <= a;
    o_data <= c[6] ? ~o_data : d;
  endtask : op
endmodule : sdpr_master_model
`default_nettype wire

// File: verif/sdpr_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sdpr_port_bench;
  typedef struct packed {logic [8:0] c; logic [17:0] a, d, ea; logic [1:0] eo;} sdpr_row_t;
  logic i_core_clk = 1'b0, i_srst = 1'b1, i_pipeline_select = 1'b0;
  logic i_chip_select_n, i_chip_select_hi, i_read_write, i_output_enable_n, i_repeat_n;
  logic i_upper_lane_enable_n, i_lower_lane_enable_n, i_addr_strobe_n, i_count_enable_n;
  logic [17:0] i_addr, i_data, o_data, o_internal_addr;
  logic [8:0]  ctl;
  logic [1:0]  o_data_oe_n;
  int          n_fail = 0, n_tests = 0;
  sdpr_row_t rows [10] = '{
    '{9'h083, 18'h3_FFFF, 18'h2_5A5A, 18'h3_FFFF, 2'h3}, '{9'h08D, 18'h0_0000, 18'h1_2345,
    18'h0_0000, 2'h3}, '{9'h0C2, 18'h0_0100, 18'h2_5A5A, 18'h3_FFFF, 2'h0},
    '{9'h1C5, 18'h0_0000, 18'h0_0000, 18'h0_0000, 2'h3}, '{9'h0CF, 18'h0_0055, 18'h1_2345,
    18'h0_0000, 2'h1}, '{9'h0E7, 18'h0_0000, 18'h0_0000, 18'h0_0000, 2'h3},
    '{9'h043, 18'h0_0010, 18'h0_0000, 18'h0_0010, 2'h3}, '{9'h0DE, 18'h0_0000, 18'h0_0000,
    18'h0_0010, 2'h3}, '{9'h093, 18'h0_0001, 18'h3_0F0F, 18'h0_0001, 2'h3},
    '{9'h0D7, 18'h0_0000, 18'h3_0F0F, 18'h0_0001, 2'h2}};
  assign {i_chip_select_n, i_chip_select_hi, i_read_write, i_output_enable_n,
    i_upper_lane_enable_n, i_lower_lane_enable_n, i_addr_strobe_n, i_count_enable_n,
    i_repeat_n} = ctl;
  sdpr_master_model mst (.i_clk(i_core_clk), .o_ctl(ctl), .o_addr(i_addr), .o_data(i_data));
  sdpr_port dut_u (.*);
  initial forever #2 i_core_clk = ~i_core_clk;
  task automatic chk(input logic [17:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Compares internal address, lane drive and only the data lanes that are expected to drive
  task automatic look(input logic [17:0] ea, d, input logic [1:0] eo);
    logic [17:0] m;
    m = {{9{~eo[1]}}, {9{~eo[0]}}};
    chk(o_internal_addr, ea);
    chk({16'h0000, o_data_oe_n}, {16'h0000, eo});
    chk(o_data & m, d & m);
  endtask : look
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial begin
    #400;
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (3) @(negedge i_core_clk);
    i_srst = 1'b0;
    chk(o_data, 18'h0_0000);
    look(18'h0_0000, 18'h0_0000, 2'h3);
    foreach (rows[i]) begin
      mst.op(rows[i].c, rows[i].a, rows[i].d);
      @(posedge i_core_clk);
      #1 look(rows[i].ea, rows[i].d, rows[i].eo);
    end
    @(negedge i_core_clk);
    i_srst = 1'b1;
    i_pipeline_select = 1'b1;
    mst.op(9'h0C3, 18'h3_FFFF, 18'h0_0000);
    i_srst = 1'b0;
    @(posedge i_core_clk);
    #1 look(18'h3_FFFF, 18'h0_0000, 2'h3);
    mst.op(9'h1C7, 18'h0_0000, 18'h0_0000);
    @(posedge i_core_clk);
    #1 look(18'h3_FFFF, 18'h2_5A5A, 2'h0);
    repeat (2) @(posedge i_core_clk);
    #1 look(18'h3_FFFF, 18'h0_0000, 2'h3);
    end_of_test();
  end
endmodule : sdpr_port_bench
bind sdpr_port sdpr_port_checker chk_u (.*);
`default_nettype wire
